/* hw/rcp_pkg.sv */
// Constants for the shared rail control and status register slice
package rcp_pkg;
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  // Register offsets
  localparam logic [7:0] OFS_SHARED_RAIL_CONTROL = 8'hae;
  localparam logic [7:0] OFS_POWER_GOOD_STATUS_A = 8'hb0;
  localparam logic [7:0] OFS_POWER_GOOD_STATUS_B = 8'hb1;
  localparam logic [7:0] OFS_POWER_FAULT_STATUS_A = 8'hb2;
  // Reset values
  localparam logic [7:0] RST_SHARED_RAIL_CONTROL = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h00;
  // Control field positions
  localparam int POS_DISCHARGE_HI = 7;
  localparam int POS_DISCHARGE_LO = 6;
  localparam int POS_EMERGENCY_OFF_SELECT = 5;
  localparam int POS_VOLTAGE_CODE_HI = 4;
  localparam int POS_VOLTAGE_CODE_LO = 1;
  localparam int POS_SHARED_RAIL_ENABLE = 0;
  // Power-good b width (bits 7:6 reserved)
  localparam int PG_B_W = 6;
  // Discharge codes
  localparam logic [1:0] DIS_NONE = 2'h0;
  localparam logic [1:0] DIS_100 = 2'h1;
  localparam logic [1:0] DIS_200 = 2'h2;
  localparam logic [1:0] DIS_500 = 2'h3;
  // Emergency off durations
  localparam int CLK_MHZ = 200;
  localparam int OFF_1_MS = 1;
  localparam int OFF_5_MS = 5;
  localparam int OFF_10_MS = 10;
  localparam int OFF_100_MS = 100;
  localparam int OFF_1_CYC = OFF_1_MS * CLK_MHZ * 1000;
  localparam int OFF_5_CYC = OFF_5_MS * CLK_MHZ * 1000;
  localparam int OFF_10_CYC = OFF_10_MS * CLK_MHZ * 1000;
  localparam int OFF_100_CYC = OFF_100_MS * CLK_MHZ * 1000;
  localparam int OFF_CNT_W = 25;
  // Emergency timer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_OFF = 2'b10
  } rcp_off_state_type;
endpackage

/* hw/rcp_fault_flags.sv */
// Sticky regulation-lost flags with write-one-to-clear
`timescale 1ns/1ps
module rcp_fault_flags
  import rcp_pkg::*;
#(
  parameter int WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Rail status and host clear
  input wire logic [WIDTH-1:0] in_regulation,
  input wire logic [WIDTH-1:0] clear_mask,
  // Flags
  output logic [WIDTH-1:0] flags
);
  logic [WIDTH-1:0] next_flags;
  logic [WIDTH-1:0] prev_good;

  // One sticky flag per rail
  for (genvar i = 0; i < WIDTH; i++) begin : g_flag
    always_comb begin
      next_flags[i] = flags[i];
      if (clear_mask[i]) begin
        next_flags[i] = 1'b0;
      end
      if (prev_good[i] && !in_regulation[i]) begin
        next_flags[i] = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      flags <= RST_STATUS[WIDTH-1:0];
      prev_good <= '0;
    end else begin
      flags <= next_flags;
      prev_good <= in_regulation;
    end
  end
endmodule

/* hw/rcp_emergency_timer.sv */
// Timed shutdown of the shared rail on emergency
`timescale 1ns/1ps
module rcp_emergency_timer
  import rcp_pkg::*;
#(
  parameter int OFF_1 = OFF_1_CYC,
  parameter int OFF_5 = OFF_5_CYC,
  parameter int OFF_10 = OFF_10_CYC,
  parameter int OFF_100 = OFF_100_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Control
  input wire logic emergency,
  input wire logic [1:0] duration_sel,
  // Status
  output logic forced_off
);
  rcp_off_state_type state, next_state;
  logic [OFF_CNT_W-1:0] count, next_count;
  logic [OFF_CNT_W-1:0] limit;

  always_comb begin
    unique case (duration_sel)
      2'h0: limit = OFF_CNT_W'(OFF_1);
      2'h1: limit = OFF_CNT_W'(OFF_5);
      2'h2: limit = OFF_CNT_W'(OFF_10);
      default: limit = OFF_CNT_W'(OFF_100);
    endcase
  end

  always_comb begin
    next_state = state;
    next_count = count;
    unique case (state)
      ST_IDLE: begin
        if (emergency) begin
          next_state = ST_OFF;
          next_count = '0;
        end
      end
      ST_OFF: begin
        if (count >= limit - 1'b1) begin
          next_state = ST_IDLE;
        end else begin
          next_count = count + 1'b1;
        end
      end
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state <= ST_IDLE;
      count <= '0;
    end else begin
      state <= next_state;
      count <= next_count;
    end
  end

  assign forced_off = (state == ST_OFF);
endmodule

/* hw/rcp_regs.sv */
// Shared rail control, power-good and power-fault register slice
`timescale 1ns/1ps
module rcp_regs
  import rcp_pkg::*;
#(
  parameter int OFF_1 = OFF_1_CYC,
  parameter int OFF_5 = OFF_5_CYC,
  parameter int OFF_10 = OFF_10_CYC,
  parameter int OFF_100 = OFF_100_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  output logic [DATA_W-1:0] reg_rdata,
  // Rail status from the analog side
  input wire logic [7:0] rail_good_a,
  input wire logic [PG_B_W-1:0] rail_good_b,
  // Factory configuration and shutdown
  input wire logic emergency_shutdown,
  input wire logic [1:0] off_duration_sel,
  input wire logic aux_reg1_in_sequence,
  input wire logic switches_b_merged,
  // Rail controls
  output logic [1:0] aux_reg1_discharge_sel,
  output logic [3:0] aux_reg1_pulldown_onehot,
  output logic [3:0] aux_reg1_voltage_code,
  output logic aux_linear_reg_1_on,
  output logic load_switch_group_b_2_on
);
  ////////////////////////////////////////////////////////////////////////////
  // Register state
  logic [DATA_W-1:0] shared_rail_control, next_shared_rail_control;
  logic [7:0] power_good_status_a, next_power_good_status_a;
  logic [PG_B_W-1:0] power_good_status_b, next_power_good_status_b;
  logic [DATA_W-1:0] next_reg_rdata;
  logic [7:0] power_fault_status_a;
  logic [7:0] fault_clear;
  logic forced_off;
  logic emergency_off_select;
  logic shared_rail_enable;
  logic rail_on;
  logic to_switch_b2;
  logic [3:0] next_pulldown;
  logic next_reg1_on, next_b2_on;

  assign emergency_off_select = shared_rail_control[POS_EMERGENCY_OFF_SELECT];
  assign shared_rail_enable = shared_rail_control[POS_SHARED_RAIL_ENABLE];

  ////////////////////////////////////////////////////////////////////////////
  // Register writes and status capture
  always_comb begin
    next_shared_rail_control = shared_rail_control;
    fault_clear = '0;
    if (reg_wr && reg_addr == OFS_SHARED_RAIL_CONTROL) begin
      next_shared_rail_control = reg_wdata;
    end
    if (reg_wr && reg_addr == OFS_POWER_FAULT_STATUS_A) begin
      fault_clear = reg_wdata;
    end
    next_power_good_status_a = rail_good_a;
    next_power_good_status_b = rail_good_b;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read mux
  always_comb begin
    next_reg_rdata = '0;
    if (reg_rd) begin
      unique case (reg_addr)
        OFS_SHARED_RAIL_CONTROL: next_reg_rdata = shared_rail_control;
        OFS_POWER_GOOD_STATUS_A: next_reg_rdata = power_good_status_a;
        OFS_POWER_GOOD_STATUS_B: next_reg_rdata = {2'h0, power_good_status_b};
        OFS_POWER_FAULT_STATUS_A: next_reg_rdata = power_fault_status_a;
        default: next_reg_rdata = '0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Fault flags and emergency timer
  rcp_fault_flags #(
    .WIDTH(8)
  ) u_faults (
    .mclk(mclk),
    .rst_n(rst_n),
    .in_regulation(rail_good_a),
    .clear_mask(fault_clear),
    .flags(power_fault_status_a)
  );

  rcp_emergency_timer #(
    .OFF_1(OFF_1),
    .OFF_5(OFF_5),
    .OFF_10(OFF_10),
    .OFF_100(OFF_100)
  ) u_timer (
    .mclk(mclk),
    .rst_n(rst_n),
    .emergency(emergency_shutdown && !emergency_off_select),
    .duration_sel(off_duration_sel),
    .forced_off(forced_off)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Rail control outputs
  always_comb begin
    rail_on = shared_rail_enable;
    if (!emergency_off_select && (forced_off || emergency_shutdown)) begin
      rail_on = 1'b0;
    end
    to_switch_b2 = aux_reg1_in_sequence && !switches_b_merged;
    next_reg1_on = to_switch_b2 ? shared_rail_enable : rail_on;
    next_b2_on = to_switch_b2 ? rail_on : shared_rail_enable;
    unique case (shared_rail_control[POS_DISCHARGE_HI:POS_DISCHARGE_LO])
      DIS_NONE: next_pulldown = 4'h1;
      DIS_100: next_pulldown = 4'h2;
      DIS_200: next_pulldown = 4'h4;
      DIS_500: next_pulldown = 4'h8;
      default: next_pulldown = 4'h1;
    endcase
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      shared_rail_control <= RST_SHARED_RAIL_CONTROL;
      power_good_status_a <= RST_STATUS;
      power_good_status_b <= RST_STATUS[PG_B_W-1:0];
      reg_rdata <= '0;
      aux_reg1_discharge_sel <= '0;
      aux_reg1_pulldown_onehot <= 4'h1;
      aux_reg1_voltage_code <= '0;
      aux_linear_reg_1_on <= 1'b0;
      load_switch_group_b_2_on <= 1'b0;
    end else begin
      shared_rail_control <= next_shared_rail_control;
      power_good_status_a <= next_power_good_status_a;
      power_good_status_b <= next_power_good_status_b;
      reg_rdata <= next_reg_rdata;
      aux_reg1_discharge_sel <= shared_rail_control[POS_DISCHARGE_HI:POS_DISCHARGE_LO];
      aux_reg1_pulldown_onehot <= next_pulldown;
      aux_reg1_voltage_code <= shared_rail_control[POS_VOLTAGE_CODE_HI:POS_VOLTAGE_CODE_LO];
      aux_linear_reg_1_on <= next_reg1_on;
      load_switch_group_b_2_on <= next_b2_on;
    end
  end
endmodule

/* testbench/rcp_regs_monitor.sv */
// Checker for the shared rail register slice ports
`timescale 1ns/1ps
module rcp_regs_monitor
  import rcp_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_rdata,
  // Rail status and controls
  input wire logic [7:0] rail_good_a,
  input wire logic [1:0] aux_reg1_discharge_sel,
  input wire logic [3:0] aux_reg1_pulldown_onehot,
  input wire logic [3:0] aux_reg1_voltage_code,
  input wire logic aux_linear_reg_1_on,
  input wire logic load_switch_group_b_2_on
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);
  logic ctl_wr;
  assign ctl_wr = reg_wr && reg_addr == OFS_SHARED_RAIL_CONTROL;
  property p_onehot;
    aux_reg1_pulldown_onehot == (4'h1 << aux_reg1_discharge_sel);
  endproperty
  a_onehot: assert property (p_onehot) else $error("pull-down select mismatch");
  property p_discharge;
    ctl_wr |-> ##2 aux_reg1_discharge_sel == $past(reg_wdata[7:6], 2);
  endproperty
  a_discharge: assert property (p_discharge) else $error("discharge field lost");
  property p_vcode;
    ctl_wr |-> ##2 aux_reg1_voltage_code == $past(reg_wdata[4:1], 2);
  endproperty
  a_vcode: assert property (p_vcode) else $error("voltage code lost");
  property p_disable;
    ctl_wr && !reg_wdata[0] |-> ##2 !aux_linear_reg_1_on && !load_switch_group_b_2_on;
  endproperty
  a_disable: assert property (p_disable) else $error("rail on while disabled");
  property p_pg_a;
    reg_rd && reg_addr == OFS_POWER_GOOD_STATUS_A && $stable(rail_good_a)
      |=> reg_rdata == $past(rail_good_a);
  endproperty
  a_pg_a: assert property (p_pg_a) else $error("power-good a mismatch");
  property p_pg_b_res;
    reg_rd && reg_addr == OFS_POWER_GOOD_STATUS_B |=> reg_rdata[7:6] == 2'h0;
  endproperty
  a_pg_b_res: assert property (p_pg_b_res) else $error("reserved bits set");
  property p_unmapped;
    reg_rd && !(reg_addr inside {8'hae, 8'hb0, 8'hb1, 8'hb2}) |=> reg_rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  property p_idle;
    !reg_rd |=> reg_rdata == 8'h00;
  endproperty
  a_idle: assert property (p_idle) else $error("read data without read");
endmodule
bind rcp_regs rcp_regs_monitor mon (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
  .rail_good_a(rail_good_a), .aux_reg1_discharge_sel(aux_reg1_discharge_sel),
  .aux_reg1_pulldown_onehot(aux_reg1_pulldown_onehot),
  .aux_reg1_voltage_code(aux_reg1_voltage_code), .aux_linear_reg_1_on(aux_linear_reg_1_on),
  .load_switch_group_b_2_on(load_switch_group_b_2_on));

/* testbench/rcp_host_model.sv */
// Host controller model driving the register port
`timescale 1ns/1ps
module rcp_host_model (
  input wire logic mclk,
  output logic reg_wr,
  output logic reg_rd,
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata
);
  initial begin
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // One-cycle write; ones written to the power-fault status register clear fault flags
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge mclk);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge mclk);
    reg_wr = 0;
    reg_wdata = ~d;
  endtask
  task rd(input logic [7:0] a);
    @(negedge mclk);
    reg_rd = 1;
    reg_addr = a;
    @(negedge mclk);
    reg_rd = 0;
    reg_addr = ~a;
  endtask
endmodule

/* testbench/tb_rcp_regs.sv */
// Testbench for the shared rail register slice
`timescale 1ns/1ps
module tb_rcp_regs;
  import rcp_pkg::*;
  logic mclk = 0;
  logic rst_n = 0;
  logic reg_wr, reg_rd, a1_on, b2_on, rd_seen = 0, emg = 0, seq = 1, mrg = 0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, ga = 0, p;
  logic [5:0] gb = 0;
  logic [1:0] dsel = 0, dis;
  logic [3:0] oh, vc;
  logic [7:0] exp_q[$];
  int n_errors = 0;
  int comparisons = 0;
  int durs[4] = '{10, 20, 30, 40};
  initial forever #2.5 mclk = ~mclk;
  rcp_host_model host (.mclk(mclk), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata));
  rcp_regs #(.OFF_1(10), .OFF_5(20), .OFF_10(30), .OFF_100(40)) uut (.mclk(mclk),
    .rst_n(rst_n), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .rail_good_a(ga), .rail_good_b(gb),
    .emergency_shutdown(emg), .off_duration_sel(dsel), .aux_reg1_in_sequence(seq),
    .switches_b_merged(mrg), .aux_reg1_discharge_sel(dis), .aux_reg1_pulldown_onehot(oh),
    .aux_reg1_voltage_code(vc), .aux_linear_reg_1_on(a1_on),
    .load_switch_group_b_2_on(b2_on));
  task chk(input string what, input logic [7:0] seen, input logic [7:0] want);
    comparisons++;
    if (seen !== want) begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, want, seen);
    end
  endtask
  task rd(input logic [7:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    host.rd(a);
  endtask
  task cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task complete_run;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Read results land one cycle after the read edge
  always @(posedge mclk) begin
    if (rd_seen) chk("reg_rdata", reg_rdata, exp_q.pop_front());
    rd_seen <= reg_rd;
  end
  initial begin
    #50000;
    n_errors++;
    complete_run;
  end
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    void'($urandom(32'hbc55));
    cyc(12);
    rst_n = 1;
    cyc(2);
    rd(OFS_POWER_GOOD_STATUS_A, RST_STATUS);
    rd(OFS_POWER_GOOD_STATUS_B, RST_STATUS);
    rd(OFS_POWER_FAULT_STATUS_A, RST_STATUS);
    chk("onehot", {4'h0, oh}, 8'h01);
    for (int i = 0; i < 4; i++) begin
      p = {i[1:0], 1'b1, 4'($urandom), 1'b1};
      host.wr(OFS_SHARED_RAIL_CONTROL, p);
      cyc(2);
      chk("discharge", {6'h0, dis}, {6'h0, p[7:6]});
      chk("onehot", {4'h0, oh}, 8'h01 << i);
      chk("vcode", {4'h0, vc}, {4'h0, p[4:1]});
      chk("b2_on", {7'h0, b2_on}, 8'h01);
      rd(OFS_SHARED_RAIL_CONTROL, p);
    end
    host.wr(OFS_SHARED_RAIL_CONTROL, 8'h00);
    cyc(2);
    chk("b2_on", {7'h0, b2_on}, 8'h00);
    ga = 8'($urandom);
    gb = 6'($urandom);
    cyc(3);
    rd(OFS_POWER_GOOD_STATUS_A, ga);
    rd(OFS_POWER_GOOD_STATUS_B, {2'h0, gb});
    host.wr(OFS_POWER_GOOD_STATUS_A, ~ga);
    host.wr(8'h55, 8'hff);
    rd(OFS_POWER_GOOD_STATUS_A, ga);
    rd(8'h55, 8'h00);
    ga = 8'hff;
    cyc(3);
    host.wr(OFS_POWER_FAULT_STATUS_A, 8'hff);
    p = 8'($urandom) & 8'h7f;
    ga = p;
    cyc(3);
    ga = 8'hff;
    cyc(3);
    rd(OFS_POWER_FAULT_STATUS_A, ~p);
    host.wr(OFS_POWER_FAULT_STATUS_A, 8'h00);
    rd(OFS_POWER_FAULT_STATUS_A, ~p);
    host.wr(OFS_POWER_FAULT_STATUS_A, 8'h0f);
    rd(OFS_POWER_FAULT_STATUS_A, ~p & 8'hf0);
    cyc(2);
    rst_n = 0;
    cyc(2);
    rst_n = 1;
    cyc(2);
    rd(OFS_POWER_FAULT_STATUS_A, RST_STATUS);
    host.wr(OFS_SHARED_RAIL_CONTROL, 8'h01);
    for (int i = 0; i < 4; i++) begin
      dsel = i[1:0];
      cyc(2);
      emg = 1;
      cyc(3);
      chk("b2_on", {7'h0, b2_on}, 8'h00);
      chk("a1_on", {7'h0, a1_on}, 8'h01);
      emg = 0;
      cyc(durs[i] - 2);
      chk("b2_on", {7'h0, b2_on}, 8'h00);
      cyc(1);
      chk("b2_on", {7'h0, b2_on}, 8'h01);
    end
    host.wr(OFS_SHARED_RAIL_CONTROL, 8'h21);
    cyc(2);
    emg = 1;
    cyc(3);
    chk("b2_on", {7'h0, b2_on}, 8'h01);
    emg = 0;
    mrg = 1;
    host.wr(OFS_SHARED_RAIL_CONTROL, 8'h01);
    cyc(2);
    emg = 1;
    cyc(3);
    chk("a1_on", {7'h0, a1_on}, 8'h00);
    chk("b2_on", {7'h0, b2_on}, 8'h01);
    emg = 0;
    cyc(durs[3] - 2);
    chk("a1_on", {7'h0, a1_on}, 8'h00);
    cyc(1);
    chk("a1_on", {7'h0, a1_on}, 8'h01);
    cyc(3);
    complete_run;
  end
endmodule
